// ### eep_bus_master.sv
// Behavioural two-wire bus master that clocks the EEPROM slave.
// Assumes the bench resolves the data line as a wired AND with a pull-up.
`default_nettype none

module eep_bus_master (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic gap(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic start();
        sda_o = 1'b1;
        gap(3);
        scl_o = 1'b1;
        gap(3);
        sda_o = 1'b0;
        gap(3);
        scl_o = 1'b0;
        gap(3);
    endtask

    task automatic stop();
        sda_o = 1'b0;
        gap(3);
        scl_o = 1'b1;
        gap(3);
        sda_o = 1'b1;
        gap(3);
    endtask

    // Data only moves while the clock is low
    task automatic clk_bit(input logic b, output logic got);
        sda_o = b;
        gap(3);
        scl_o = 1'b1;
        gap(3);
        got = sda_i;
        gap(3);
        scl_o = 1'b0;
        gap(3);
    endtask

    task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], rx[i]);
        end
        clk_bit(ack_tx, a);
        ack_rx = !a;
    endtask
endmodule

`default_nettype wire

// ### eep_mem.sv
// Byte-wide storage array of the EEPROM with one write and one read port.
// Assumes writes come only from the programming cycle of the slave logic.
`default_nettype none

module eep_mem
    import eep_pkg::*;
(
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [ADDR_W-1:0] raddr_i,
    output logic [7:0] rdata_o
);

    logic [7:0] mem [MEM_WORDS];

    // ****************************************************************
    // Delivered with every byte erased
    // ****************************************************************
    initial begin
        for (int i = 0; i < MEM_WORDS; i++) begin
            mem[i] = ERASED_BYTE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem[raddr_i];

endmodule

`default_nettype wire

// ### eep_monitor.sv
// Port-level concurrent checks for the serial EEPROM slave.
// Assumes it is bound to every eep_slave and sees only that module's ports.
`default_nettype none

module eep_monitor
    import eep_pkg::*;
#(
    parameter int KBITS = 8,
    parameter int PROG_TIME_US = PROG_DEFAULT_US
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic chip_sel_pin0_i,
    input wire logic chip_sel_pin1_i,
    input wire logic chip_sel_pin2_i,
    input wire logic write_inhibit_in_i,
    input wire logic prog_busy_o
);
    timeunit 1ns;
    timeprecision 1ns;

    localparam int PROG_LEN = 8 + PROG_TIME_US * NS_PER_US / CLK_PERIOD_NS;
    logic [TIMER_W-1:0] busy_cnt_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // ****************************************************************
    // Helper: length of the current program cycle
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i || !prog_busy_o) begin
            busy_cnt_reg <= '0;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 1'b1;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_open_drain;
        sda_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda output value not low");

    property p_busy_released;
        prog_busy_o |-> sda_oe_n_o;
    endproperty
    a_busy_released: assert property (p_busy_released) else $error("data line driven while busy");

    property p_drive_after_fall;
        $fell(sda_oe_n_o) |-> !$past(scl_i) && ($past(scl_i, 2) || $past(scl_i, 3));
    endproperty
    a_drive_after_fall: assert property (p_drive_after_fall) else $error("drive not after clock fall");

    property p_busy_length;
        $fell(prog_busy_o) |-> busy_cnt_reg == TIMER_W'(PROG_LEN);
    endproperty
    a_busy_length: assert property (p_busy_length) else $error("program cycle length wrong");

    property p_busy_after_stop;
        $rose(prog_busy_o) |-> $past(scl_i) && $past(scl_i, 2) && $past(sda_i) && !$past(sda_i, 2);
    endproperty
    a_busy_after_stop: assert property (p_busy_after_stop) else $error("program start without stop");

    property p_inhibit_no_prog;
        $rose(prog_busy_o) |-> !write_inhibit_in_i;
    endproperty
    a_inhibit_no_prog: assert property (p_inhibit_no_prog) else $error("program while inhibited");

    property p_stable_clock_high;
        scl_i && $past(scl_i) && $past(scl_i, 2) |-> $stable(sda_oe_n_o);
    endproperty
    a_stable_clock_high: assert property (p_stable_clock_high) else $error("drive changed with clock high");

    property p_idle_after_reset;
        $fell(reset_i) |-> sda_oe_n_o && !prog_busy_o;
    endproperty
    a_idle_after_reset: assert property (p_idle_after_reset) else $error("not idle after reset");

    c_prog: cover property ($rose(prog_busy_o));
    c_drive: cover property ($fell(sda_oe_n_o));
    c_prog_end: cover property ($fell(prog_busy_o));
endmodule

bind eep_slave eep_monitor #(.KBITS(KBITS), .PROG_TIME_US(PROG_TIME_US)) u_mon (.clk_i(clk_i), .reset_i(reset_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .chip_sel_pin0_i(chip_sel_pin0_i),
    .chip_sel_pin1_i(chip_sel_pin1_i), .chip_sel_pin2_i(chip_sel_pin2_i),
    .write_inhibit_in_i(write_inhibit_in_i), .prog_busy_o(prog_busy_o));

`default_nettype wire

// ### eep_pkg.sv
// Constants, state encoding and helpers shared by the serial EEPROM slave.
// Assumes a single 50 MHz clock domain and bus pins sampled synchronously.
`default_nettype none

package eep_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int NS_PER_US = 1000;
    localparam int PROG_DEFAULT_US = 5000;
    localparam int TIMER_W = 24;

    // ****************************************************************
    // Select byte layout
    // ****************************************************************
    // Type code value is arbitrary for this model
    localparam logic [3:0] DEV_TYPE_ID = 4'h6;
    localparam int SEL_TYPE_MSB = 7;
    localparam int SEL_TYPE_LSB = 4;
    localparam int SEL_CE_MSB = 3;
    localparam int SEL_CE_LSB = 1;
    localparam int SEL_RW_BIT = 0;

    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam int ADDR_W = 10;
    localparam int MEM_WORDS = 1024;
    localparam int PAGE_BYTES = 8;
    localparam logic [ADDR_W-1:0] PAGE_OFS_MASK = 10'h00F;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_DONE = 4'h9;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_SEL,
        PH_ADDR,
        PH_WDATA,
        PH_RDATA,
        PH_PROG
    } eep_state_t;

    // Valid address bits for a 1, 2, 4 or 8 kbit array
    function automatic logic [ADDR_W-1:0] eep_addr_mask(input int kbits);
        case (kbits)
            1: eep_addr_mask = 10'h07F;
            2: eep_addr_mask = 10'h0FF;
            4: eep_addr_mask = 10'h1FF;
            default: eep_addr_mask = 10'h3FF;
        endcase
    endfunction

    // Chip enable bits that are really compared (bit0 = pin 0)
    function automatic logic [2:0] eep_ce_mask(input int kbits);
        case (kbits)
            1, 2: eep_ce_mask = 3'h7;
            4: eep_ce_mask = 3'h6;
            default: eep_ce_mask = 3'h4;
        endcase
    endfunction

endpackage

`default_nettype wire

// ### eep_slave.sv
// Two-wire bus slave of a small serial EEPROM: select decode, byte and page
// write with a self-timed program cycle, and sequential read.
// Assumes scl_i and sda_i are already synchronous to clk_i; the pin pad
// resolves sda from sda_o and sda_oe_n_o (low = pull line low).
//
// What this block does
// - Sample the data line on each rising clock edge while receiving.
// - Upper four select bits must equal the fixed device type.
// - Compared chip-enable bits must equal their chip-enable input pins.
// - Larger variants take select bits 1 and 2 as upper address bits.
// - Select bit 0 is direction: 1 read, 0 write.
// - On a match, pull data low during the ninth clock as acknowledge.
// - On a mismatch, no acknowledge, release the bus, go to standby.
// - Write: acknowledge select, receive and acknowledge address, then data.
// - Programming starts only on stop in the slot right after a data ack.
// - After programming, address counter points one past the last byte.
// - During programming, release data and ignore everything incl. start.
// - Write inhibit high: no ack on data, no write, memory unchanged.
// - Single byte write: one data byte then stop, acknowledged if allowed.
// - One to eight data bytes are programmed in one cycle.
// - Page write increments only the low address bits, wrapping in page.
// - While programming, select gets no ack; afterwards it is acknowledged.
// - Reads are served whatever the write inhibit level.
// - Address counter increments after every byte delivered in a read.
// - Start: data falls with clock high; stop: data rises with clock high.
// - Write inhibit still acknowledges select and address bytes.
// - In reads, sample master ack at ninth bit; no ack means standby.
// - Read address wraps from the last address to zero.
`default_nettype none

module eep_slave
    import eep_pkg::*;
#(
    parameter int KBITS = 8,
    parameter int PROG_TIME_US = PROG_DEFAULT_US
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic chip_sel_pin0_i,
    input wire logic chip_sel_pin1_i,
    input wire logic chip_sel_pin2_i,
    input wire logic write_inhibit_in_i,
    output logic prog_busy_o
);

    // ****************************************************************
    // Derived constants
    // ****************************************************************
    localparam int PROG_CYCLES_RAW = (PROG_TIME_US * NS_PER_US) / CLK_PERIOD_NS;
    localparam int PROG_CYCLES = (PROG_CYCLES_RAW < 1) ? 1 : PROG_CYCLES_RAW;
    localparam logic [TIMER_W-1:0] PROG_LAST = TIMER_W'(PROG_CYCLES - 1);
    localparam logic [ADDR_W-1:0] ADDR_MASK = eep_addr_mask(KBITS);
    localparam logic [2:0] CE_MASK = eep_ce_mask(KBITS);

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        eep_state_t state;
        logic scl_q;
        logic sda_q;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] sel;
        logic [ADDR_W-1:0] addr;
        logic [2:0] slot;
        logic [PAGE_BYTES-1:0] vld;
        logic [PAGE_BYTES-1:0][7:0] buf_data;
        logic [PAGE_BYTES-1:0][ADDR_W-1:0] buf_addr;
        logic [3:0] prog_idx;
        logic [TIMER_W-1:0] timer;
        logic sda_oe_n;
    } eep_regs_t;

    localparam eep_regs_t REGS_RESET = '{
        state: PH_IDLE,
        scl_q: 1'b1,
        sda_q: 1'b1,
        bitcnt: 4'h0,
        shreg: 8'h00,
        sel: 8'h00,
        addr: 10'h000,
        slot: 3'h0,
        vld: 8'h00,
        buf_data: '0,
        buf_addr: '0,
        prog_idx: 4'h0,
        timer: 24'h000000,
        sda_oe_n: 1'b1
    };

    eep_regs_t r_reg;
    eep_regs_t r_next;

    logic [7:0] mem_rdata;
    logic mem_we;
    logic [2:0] prog_slot;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Page write increment: only the low offset bits move
    function automatic logic [ADDR_W-1:0] page_incr(input logic [ADDR_W-1:0] a);
        page_incr = ((a & ~PAGE_OFS_MASK) | ((a + 10'h001) & PAGE_OFS_MASK)) & ADDR_MASK;
    endfunction

    // Linear read increment with wrap to zero
    function automatic logic [ADDR_W-1:0] read_incr(input logic [ADDR_W-1:0] a);
        read_incr = (a + 10'h001) & ADDR_MASK;
    endfunction

    function automatic logic sel_match(input logic [7:0] s, input logic [2:0] pins);
        sel_match = (s[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEV_TYPE_ID)
            && (((s[SEL_CE_MSB:SEL_CE_LSB] ^ pins) & CE_MASK) == 3'h0);
    endfunction

    // ****************************************************************
    // Array
    // ****************************************************************
    // One buffered byte reaches the array per clock while programming
    assign prog_slot = r_reg.prog_idx[2:0];
    assign mem_we = (r_reg.state == PH_PROG) && !r_reg.prog_idx[3] && r_reg.vld[prog_slot];

    eep_mem u_mem (
        .clk_i(clk_i),
        .we_i(mem_we),
        .waddr_i(r_reg.buf_addr[prog_slot]),
        .wdata_i(r_reg.buf_data[prog_slot]),
        .raddr_i(r_reg.addr),
        .rdata_o(mem_rdata)
    );

    // ****************************************************************
    // Protocol engine
    // ****************************************************************
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_seen;
        logic stop_seen;
        logic [2:0] pins;
        logic [ADDR_W-1:0] hi;

        r_next = r_reg;
        r_next.scl_q = scl_i;
        r_next.sda_q = sda_i;
        scl_rise = !r_reg.scl_q && scl_i;
        scl_fall = r_reg.scl_q && !scl_i;
        start_seen = r_reg.scl_q && scl_i && r_reg.sda_q && !sda_i;
        stop_seen = r_reg.scl_q && scl_i && !r_reg.sda_q && sda_i;
        pins = {chip_sel_pin2_i, chip_sel_pin1_i, chip_sel_pin0_i};
        // Upper address bits ride in the select byte of larger arrays
        hi = '0;
        hi[8] = r_reg.sel[1] && (KBITS >= 4);
        hi[9] = r_reg.sel[2] && (KBITS >= 8);

        if (r_reg.state == PH_PROG) begin
            // Bus is ignored entirely while the array is programmed
            r_next.sda_oe_n = 1'b1;
            if (!r_reg.prog_idx[3]) begin
                r_next.prog_idx = r_reg.prog_idx + 4'h1;
            end else if (r_reg.timer == PROG_LAST) begin
                // Counter already sits one past the last byte taken in
                r_next.state = PH_IDLE;
                r_next.vld = '0;
                r_next.timer = '0;
            end else begin
                r_next.timer = r_reg.timer + 24'h000001;
            end
        end else if (start_seen) begin
            r_next.state = PH_SEL;
            r_next.bitcnt = 4'h0;
            r_next.vld = '0;
            r_next.slot = 3'h0;
            r_next.sda_oe_n = 1'b1;
        end else if (stop_seen) begin
            r_next.sda_oe_n = 1'b1;
            r_next.state = PH_IDLE;
            // The stop's own clock rise has already counted one bit, so a
            // count of one marks the slot right after a data acknowledge
            if (r_reg.state == PH_WDATA && r_reg.bitcnt == 4'h1 && r_reg.vld != '0) begin
                r_next.state = PH_PROG;
                r_next.prog_idx = 4'h0;
                r_next.timer = '0;
            end
        end else begin
            case (r_reg.state)
                PH_SEL, PH_ADDR, PH_WDATA: begin
                    if (scl_rise) begin
                        if (r_reg.bitcnt < BIT_ACK) begin
                            r_next.shreg = {r_reg.shreg[6:0], sda_i};
                            r_next.bitcnt = r_reg.bitcnt + 4'h1;
                        end else if (r_reg.bitcnt == BIT_ACK) begin
                            r_next.bitcnt = BIT_DONE;
                        end
                    end else if (scl_fall && r_reg.bitcnt == BIT_ACK) begin
                        case (r_reg.state)
                            PH_SEL: begin
                                r_next.sel = r_reg.shreg;
                                if (sel_match(r_reg.shreg, pins)) begin
                                    r_next.sda_oe_n = 1'b0;
                                end else begin
                                    r_next.state = PH_IDLE;
                                end
                            end
                            PH_ADDR: begin
                                r_next.addr = (hi | {2'b00, r_reg.shreg}) & ADDR_MASK;
                                r_next.sda_oe_n = 1'b0;
                            end
                            default: begin
                                if (write_inhibit_in_i) begin
                                    r_next.state = PH_IDLE;
                                end else begin
                                    r_next.buf_data[r_reg.slot] = r_reg.shreg;
                                    r_next.buf_addr[r_reg.slot] = r_reg.addr;
                                    r_next.vld[r_reg.slot] = 1'b1;
                                    r_next.slot = r_reg.slot + 3'h1;
                                    r_next.addr = page_incr(r_reg.addr);
                                    r_next.sda_oe_n = 1'b0;
                                end
                            end
                        endcase
                    end else if (scl_fall && r_reg.bitcnt == BIT_DONE) begin
                        r_next.bitcnt = 4'h0;
                        r_next.sda_oe_n = 1'b1;
                        if (r_reg.state == PH_SEL) begin
                            if (r_reg.sel[SEL_RW_BIT]) begin
                                // Read needs no write permission
                                r_next.state = PH_RDATA;
                                r_next.shreg = mem_rdata;
                                r_next.sda_oe_n = mem_rdata[7];
                                r_next.addr = read_incr(r_reg.addr);
                            end else begin
                                r_next.state = PH_ADDR;
                            end
                        end else begin
                            r_next.state = PH_WDATA;
                        end
                    end
                end
                PH_RDATA: begin
                    if (scl_rise) begin
                        if (r_reg.bitcnt < BIT_ACK) begin
                            r_next.bitcnt = r_reg.bitcnt + 4'h1;
                        end else if (r_reg.bitcnt == BIT_ACK) begin
                            // Ninth rise: a high line is the master's no-acknowledge
                            if (sda_i) begin
                                r_next.state = PH_IDLE;
                                r_next.sda_oe_n = 1'b1;
                            end else begin
                                r_next.bitcnt = BIT_DONE;
                            end
                        end
                    end else if (scl_fall) begin
                        if (r_reg.bitcnt > 4'h0 && r_reg.bitcnt < BIT_ACK) begin
                            r_next.shreg = {r_reg.shreg[6:0], 1'b0};
                            r_next.sda_oe_n = r_reg.shreg[6];
                        end else if (r_reg.bitcnt == BIT_ACK) begin
                            r_next.sda_oe_n = 1'b1;
                        end else if (r_reg.bitcnt == BIT_DONE) begin
                            r_next.bitcnt = 4'h0;
                            r_next.shreg = mem_rdata;
                            r_next.sda_oe_n = mem_rdata[7];
                            r_next.addr = read_incr(r_reg.addr);
                        end
                    end
                end
                default: begin
                    r_next.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            r_reg <= REGS_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign sda_o = 1'b0;
    assign sda_oe_n_o = r_reg.sda_oe_n;
    assign prog_busy_o = (r_reg.state == PH_PROG);

endmodule

`default_nettype wire

// ### test_i2c_serial_eeprom_slave.sv
// Self-checking bench for the serial EEPROM slave with a bus master model.
// Assumes a 50 MHz clock and a shortened program cycle.
`default_nettype none

module test_i2c_serial_eeprom_slave
    import eep_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, reset, scl, sda_m, sda_line, sda_o, sda_oe_n, wi, busy, ack;
    logic [2:0] ce;
    logic [7:0] rx;
    int n_fail;
    int samples_checked;

    assign sda_line = sda_m & (sda_oe_n | sda_o);

    eep_slave #(.KBITS(8), .PROG_TIME_US(4)) u_dut (.clk_i(clk), .reset_i(reset), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .chip_sel_pin0_i(ce[0]), .chip_sel_pin1_i(ce[1]),
        .chip_sel_pin2_i(ce[2]), .write_inhibit_in_i(wi), .prog_busy_o(busy));
    eep_bus_master u_mst (.clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_o(sda_m));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] sb(input logic [1:0] pg, input logic rw);
        return {DEV_TYPE_ID, 1'b1, pg, rw};
    endfunction

    task automatic wait_idle();
        int i;
        i = 0;
        while (busy === 1'b1 && i < 400) begin
            @(negedge clk);
            i++;
        end
        if (i == 400) begin
            n_fail++;
            tally_and_finish();
        end
    endtask

    task automatic sel(input logic [7:0] code, input logic exp);
        u_mst.start();
        u_mst.xfer(code, 1'b1, rx, ack);
        chk("select ack", {7'h00, exp}, {7'h00, ack});
    endtask

    task automatic wbyte(input logic [7:0] d, input logic exp);
        u_mst.xfer(d, 1'b1, rx, ack);
        chk("write ack", {7'h00, exp}, {7'h00, ack});
    endtask

    task automatic rbyte(input logic [7:0] exp, input logic last);
        u_mst.xfer(8'hFF, last, rx, ack);
        chk("read data", exp, rx);
    endtask

    task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d);
        sel(sb(2'h0, 1'b0), 1'b1);
        wbyte(a, 1'b1);
        for (int i = 0; i < n; i++) begin
            wbyte(d + 8'(i), 1'b1);
        end
        u_mst.stop();
        chk("busy", 8'h01, {7'h00, busy});
        sel(sb(2'h0, 1'b0), 1'b0);
        u_mst.stop();
        wait_idle();
    endtask

    task automatic rd_at(input logic [1:0] pg, input logic [7:0] a, input logic [7:0] e0, e1, e2);
        sel(sb(pg, 1'b0), 1'b1);
        wbyte(a, 1'b1);
        sel(sb(pg, 1'b1), 1'b1);
        rbyte(e0, 1'b0);
        rbyte(e1, 1'b0);
        rbyte(e2, 1'b1);
        u_mst.stop();
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_write();
        wr(8'h00, 1, 8'h5A);
        wr(8'h12, 1, 8'h77);
        wr(8'h1E, 4, 8'hC0);
        sel(sb(2'h0, 1'b1), 1'b1);
        rbyte(8'h77, 1'b0);
        rbyte(8'hFF, 1'b1);
        u_mst.stop();
        rd_at(2'h0, 8'h1E, 8'hC0, 8'hC1, 8'hFF);
        rd_at(2'h0, 8'h10, 8'hC2, 8'hC3, 8'h77);
        rd_at(2'h3, 8'hFE, 8'hFF, 8'hFF, 8'h5A);
        $display("test write and read done");
    endtask

    task automatic t_mismatch();
        sel({4'h5, 1'b1, 3'h0}, 1'b0);
        wbyte(8'h00, 1'b0);
        u_mst.stop();
        sel({DEV_TYPE_ID, 4'h0}, 1'b0);
        u_mst.stop();
        ce = 3'h7;
        sel(sb(2'h0, 1'b1), 1'b1);
        rbyte(8'hFF, 1'b1);
        u_mst.stop();
        sel(sb(2'h0, 1'b0), 1'b1);
        wbyte(8'h40, 1'b1);
        u_mst.stop();
        chk("busy", 8'h00, {7'h00, busy});
        ce = 3'h4;
        $display("test select mismatch done");
    endtask

    task automatic t_inhibit();
        wi = 1'b1;
        sel(sb(2'h0, 1'b0), 1'b1);
        wbyte(8'h12, 1'b1);
        wbyte(8'h00, 1'b0);
        u_mst.stop();
        chk("busy", 8'h00, {7'h00, busy});
        rd_at(2'h0, 8'h11, 8'hC3, 8'h77, 8'hFF);
        wi = 1'b0;
        $display("test write inhibit done");
    endtask

    initial begin
        n_fail = 0;
        samples_checked = 0;
        reset = 1'b1;
        ce = 3'h4;
        wi = 1'b0;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        t_write();
        t_mismatch();
        t_inhibit();
        tally_and_finish();
    end
endmodule

`default_nettype wire
